// ===== logic/sdio_core.sv
// contact i/o control logic of a single-axis servo driver
//
// Our own choices: the APB register port and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - servo enable energises motor under closed loop; release removes power.
// - pole parameter at either special setting makes enable start pole estimation.
// - rising alarm clear cancels a latched alarm, but only while servo enable is off.
// - torque clamp input active applies torque limit, else limit off.
// - forward limit low inhibits forward motion.
// - reverse limit low inhibits reverse motion.
// - home switch marks origin area and is used while homing.
// - homing start begins a homing sequence.
// - command pulses counted only while pulse gate is high.
// - deviation clear zeroes the position error counter.
// - deviation clear sets command position to measured position.
// - ready only with main power present and no alarm latched.
// - fault ok output high in normal running, low after alarm trip.
// - positioning complete while error within in-position range.
// - homing done asserted after homing finishes successfully.
// - pulse input supports pulse-direction, fwd/rev trains and quadrature.
// - brake release asserted while motor energised (enable on, main power present, no alarm).
module sdio_core (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic servo_enable_in,
  input wire logic alarm_clear_in,
  input wire logic torque_clamp_in,
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  input wire logic home_switch_in,
  input wire logic homing_start_in,
  input wire logic pulse_input_gate,
  input wire logic deviation_clear_in,
  input wire logic cmd_pulse_pos,
  input wire logic cmd_dir_pos,
  input wire logic fault_trip_in,
  input wire logic enc_step_in,
  input wire logic enc_dir_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic servo_ready_out,
  output logic fault_ok_out,
  output logic motor_power_out,
  output logic torque_limit_out,
  output logic fwd_inhibit_out,
  output logic rev_inhibit_out,
  output logic pole_est_out,
  output logic in_position_out,
  output logic homing_done_out,
  output logic homing_active_out,
  output logic brake_release_out
);
  // ----------------------------------------
  // input synchronisers and filters
  // ----------------------------------------
  logic [sdio_pkg::NUM_CONTACTS-1:0] raw_w;
  logic [sdio_pkg::NUM_CONTACTS-1:0] s1_q;
  logic [sdio_pkg::NUM_CONTACTS-1:0] s2_q;
  logic [sdio_pkg::NUM_CONTACTS-1:0] filt_q;
  logic [sdio_pkg::NUM_CONTACTS-1:0] filt_prev_q;
  assign raw_w = {enc_dir_in, enc_step_in, fault_trip_in, cmd_dir_pos, cmd_pulse_pos, deviation_clear_in,
                  pulse_input_gate, homing_start_in, home_switch_in, rev_limit_in, fwd_limit_in,
                  {servo_enable_in ^ 1'b0}};
  genvar gi;
  generate
    for (gi = 0; gi < sdio_pkg::NUM_CONTACTS; gi++) begin : g_in
      logic [2:0] cnt_q;
      always_ff @(posedge mclk_in) begin
        if (rst_in) begin
          s1_q[gi] <= 1'b0;
          s2_q[gi] <= 1'b0;
          filt_q[gi] <= 1'b0;
          cnt_q <= 3'h0;
        end else begin
          s1_q[gi] <= raw_w[gi];
          s2_q[gi] <= s1_q[gi];
          // a level must hold several cycles before it is believed, rejecting contact bounce
          if (s2_q[gi] == filt_q[gi]) begin
            cnt_q <= 3'h0;
          end else if (cnt_q == 3'(sdio_pkg::FILT_CYCLES - 1)) begin
            filt_q[gi] <= s2_q[gi];
            cnt_q <= 3'h0;
          end else begin
            cnt_q <= cnt_q + 3'h1;
          end
        end
      end
    end
  endgenerate
  // alarm clear is not in the vector above; it gets its own two-stage path and filter
  logic clr_s1_q;
  logic clr_s2_q;
  logic clr_f_q;
  logic clr_prev_q;
  logic [2:0] clr_cnt_q;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      clr_s1_q <= 1'b0;
      clr_s2_q <= 1'b0;
      clr_f_q <= 1'b0;
      clr_prev_q <= 1'b0;
      clr_cnt_q <= 3'h0;
      filt_prev_q <= '0;
    end else begin
      clr_s1_q <= alarm_clear_in;
      clr_s2_q <= clr_s1_q;
      clr_prev_q <= clr_f_q;
      filt_prev_q <= filt_q;
      if (clr_s2_q == clr_f_q) begin
        clr_cnt_q <= 3'h0;
      end else if (clr_cnt_q == 3'(sdio_pkg::FILT_CYCLES - 1)) begin
        clr_f_q <= clr_s2_q;
        clr_cnt_q <= 3'h0;
      end else begin
        clr_cnt_q <= clr_cnt_q + 3'h1;
      end
    end
  end
  // ----------------------------------------
  // named filtered contacts
  // ----------------------------------------
  wire son_w = filt_q[0];
  wire fwd_ok_w = filt_q[1];
  wire rev_ok_w = filt_q[2];
  wire home_sw_w = filt_q[3];
  wire home_rise_w = filt_q[4] & ~filt_prev_q[4];
  wire gate_w = filt_q[5];
  wire dev_clr_w = filt_q[6];
  wire cp_w = filt_q[7];
  wire cd_w = filt_q[8];
  wire trip_w = filt_q[9];
  wire enc_rise_w = filt_q[10] & ~filt_prev_q[10];
  wire enc_dir_w = filt_q[11];
  wire clr_rise_w = clr_f_q & ~clr_prev_q;
  wire cp_rise_w = cp_w & ~filt_prev_q[7];
  wire cp_fall_w = ~cp_w & filt_prev_q[7];
  wire cd_rise_w = cd_w & ~filt_prev_q[8];
  wire cd_fall_w = ~cd_w & filt_prev_q[8];
  // torque clamp bypasses the vector; sample it through its own pair
  logic tq_s1_q;
  logic tq_s2_q;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      tq_s1_q <= 1'b0;
      tq_s2_q <= 1'b0;
    end else begin
      tq_s1_q <= torque_clamp_in;
      tq_s2_q <= tq_s1_q;
    end
  end
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [31:0] ctrl_q;
  logic [31:0] inpos_q;
  logic [31:0] cmd_pos_q;
  logic [31:0] meas_pos_q;
  logic fault_q;
  logic pole_busy_q;
  logic [4:0] pole_cnt_q;
  logic son_prev_q;
  sdio_pkg::sdio_home_e home_q;
  wire [1:0] fmt_w = ctrl_q[sdio_pkg::CTRL_FMT_LSB +: 2];
  wire [3:0] pole_w = ctrl_q[sdio_pkg::CTRL_POLE_LSB +: 4];
  wire main_pwr_w = ctrl_q[sdio_pkg::CTRL_MAINPWR_BIT];
  wire [31:0] err_w = cmd_pos_q - meas_pos_q;
  wire [31:0] abs_err_w = err_w[31] ? (32'h0 - err_w) : err_w;
  wire energise_w = son_w & ~fault_q & main_pwr_w;
  wire pole_sel_w = (pole_w == sdio_pkg::POLE_EST_A) | (pole_w == sdio_pkg::POLE_EST_B);
  // ----------------------------------------
  // pulse format decode
  // ----------------------------------------
  logic step_w;
  logic dir_w;
  always_comb begin
    step_w = 1'b0;
    dir_w = 1'b0;
    case (fmt_w)
      2'h0: begin
        step_w = cp_rise_w;
        dir_w = cd_w;
      end
      2'h1: begin
        step_w = cp_rise_w | cd_rise_w;
        dir_w = ~cp_rise_w;
      end
      2'h2: begin
        step_w = cp_rise_w | cp_fall_w | cd_rise_w | cd_fall_w;
        dir_w = (cp_rise_w & ~cd_w) | (cp_fall_w & cd_w) | (cd_rise_w & cp_w) | (cd_fall_w & ~cp_w);
      end
      default: step_w = 1'b0;
    endcase
  end
  wire fwd_blk_w = dir_w ? 1'b0 : ~fwd_ok_w;
  wire rev_blk_w = dir_w ? ~rev_ok_w : 1'b0;
  wire step_ok_w = step_w & gate_w & energise_w & ~fwd_blk_w & ~rev_blk_w;
  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  wire wr_w = psel & penable & pwrite;
  wire rd_w = psel & penable & ~pwrite;
  wire hit_w = (paddr == sdio_pkg::ADDR_CTRL) | (paddr == sdio_pkg::ADDR_STATUS) | (paddr == sdio_pkg::ADDR_INPOS)
               | (paddr == sdio_pkg::ADDR_CMDPOS) | (paddr == sdio_pkg::ADDR_MEASPOS) | (paddr == sdio_pkg::ADDR_ERR)
               | (paddr == sdio_pkg::ADDR_FAULT);
  wire [31:0] status_w = {22'h0, ~fwd_ok_w, ~rev_ok_w, tq_s2_q, pole_busy_q, home_q == sdio_pkg::HOME_SEEK,
                          home_q == sdio_pkg::HOME_DONE, abs_err_w <= inpos_q, energise_w, ~fault_q,
                          main_pwr_w & ~fault_q};
  wire [31:0] rmux_w = (paddr == sdio_pkg::ADDR_CTRL) ? ctrl_q :
                       (paddr == sdio_pkg::ADDR_STATUS) ? status_w :
                       (paddr == sdio_pkg::ADDR_INPOS) ? inpos_q :
                       (paddr == sdio_pkg::ADDR_CMDPOS) ? cmd_pos_q :
                       (paddr == sdio_pkg::ADDR_MEASPOS) ? meas_pos_q :
                       (paddr == sdio_pkg::ADDR_ERR) ? err_w :
                       (paddr == sdio_pkg::ADDR_FAULT) ? {31'h0, fault_q} : 32'h0;
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
      ctrl_q <= sdio_pkg::CTRL_RESET;
      inpos_q <= sdio_pkg::INPOS_RESET;
    end else begin
      // one wait state: pready rises in the second access cycle
      pready <= psel & penable & ~pready;
      pslverr <= psel & penable & ~pready & ~hit_w;
      prdata <= (rd_w & ~pready) ? rmux_w : 32'h0;
      // writes land on the completing edge, when the master sees pready
      if (wr_w & pready & (paddr == sdio_pkg::ADDR_CTRL))
        ctrl_q <= pwdata;
      if (wr_w & pready & (paddr == sdio_pkg::ADDR_INPOS))
        inpos_q <= pwdata;
    end
  end
  // ----------------------------------------
  // alarm, pole estimation, positions
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      fault_q <= 1'b0;
      son_prev_q <= 1'b0;
      pole_busy_q <= 1'b0;
      pole_cnt_q <= 5'h0;
      cmd_pos_q <= 32'h0;
      meas_pos_q <= 32'h0;
    end else begin
      son_prev_q <= son_w;
      // a new trip wins over a clear arriving in the same cycle
      if (trip_w)
        fault_q <= 1'b1;
      else if (clr_rise_w & ~son_w)
        fault_q <= 1'b0;
      if (son_w & ~son_prev_q & pole_sel_w & energise_w) begin
        pole_busy_q <= 1'b1;
        pole_cnt_q <= 5'h0;
      end else if (pole_busy_q) begin
        pole_cnt_q <= pole_cnt_q + 5'h1;
        if (pole_cnt_q == 5'(sdio_pkg::POLE_CYCLES - 1) || !energise_w) begin
          pole_busy_q <= 1'b0;
        end
      end
      if (enc_rise_w)
        meas_pos_q <= enc_dir_w ? meas_pos_q - 32'h1 : meas_pos_q + 32'h1;
      if (dev_clr_w) begin
        cmd_pos_q <= meas_pos_q;
      end else if (step_ok_w) begin
        cmd_pos_q <= dir_w ? cmd_pos_q - 32'h1 : cmd_pos_q + 32'h1;
      end
    end
  end
  // ----------------------------------------
  // homing sequence
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      home_q <= sdio_pkg::HOME_IDLE;
    end else begin
      case (home_q)
        sdio_pkg::HOME_IDLE: begin
          if (home_rise_w & energise_w) begin
            home_q <= sdio_pkg::HOME_SEEK;
          end
        end
        sdio_pkg::HOME_SEEK: begin
          if (!energise_w) begin
            home_q <= sdio_pkg::HOME_IDLE;
          end else if (home_sw_w) begin
            home_q <= sdio_pkg::HOME_DONE;
          end
        end
        sdio_pkg::HOME_DONE: begin
          if (home_rise_w & energise_w) begin
            home_q <= sdio_pkg::HOME_SEEK;
          end else if (fault_q) begin
            home_q <= sdio_pkg::HOME_IDLE;
          end
        end
        default: home_q <= sdio_pkg::HOME_IDLE;
      endcase
    end
  end
  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      servo_ready_out <= 1'b0;
      fault_ok_out <= 1'b0;
      motor_power_out <= 1'b0;
      torque_limit_out <= 1'b0;
      fwd_inhibit_out <= 1'b1;
      rev_inhibit_out <= 1'b1;
      pole_est_out <= 1'b0;
      in_position_out <= 1'b0;
      homing_done_out <= 1'b0;
      homing_active_out <= 1'b0;
      brake_release_out <= 1'b0;
    end else begin
      servo_ready_out <= main_pwr_w & ~fault_q & ~trip_w;
      fault_ok_out <= ~fault_q & ~trip_w;
      motor_power_out <= energise_w & ~trip_w;
      torque_limit_out <= tq_s2_q;
      fwd_inhibit_out <= ~fwd_ok_w;
      rev_inhibit_out <= ~rev_ok_w;
      pole_est_out <= pole_busy_q;
      in_position_out <= abs_err_w <= inpos_q;
      homing_done_out <= home_q == sdio_pkg::HOME_DONE;
      homing_active_out <= home_q == sdio_pkg::HOME_SEEK;
      brake_release_out <= energise_w & ~trip_w;
    end
  end
endmodule

// ===== shared/sdio_pkg.sv
// constants and types for the servo driver contact i/o block
package sdio_pkg;
  // ----------------------------------------
  // register map (apb byte addresses)
  // ----------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_INPOS = 8'h08;
  localparam logic [7:0] ADDR_CMDPOS = 8'h0C;
  localparam logic [7:0] ADDR_MEASPOS = 8'h10;
  localparam logic [7:0] ADDR_ERR = 8'h14;
  localparam logic [7:0] ADDR_FAULT = 8'h18;
  // ----------------------------------------
  // ctrl fields
  // ----------------------------------------
  localparam int CTRL_FMT_LSB = 0;
  localparam int CTRL_POLE_LSB = 4;
  localparam int CTRL_MAINPWR_BIT = 8;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0100;
  localparam logic [3:0] POLE_EST_A = 4'h4;
  localparam logic [3:0] POLE_EST_B = 4'h5;
  localparam logic [31:0] INPOS_RESET = 32'h0000_000A;
  // ----------------------------------------
  // status bits
  // ----------------------------------------
  localparam int ST_READY = 0;
  localparam int ST_FAULTOK = 1;
  localparam int ST_ENERGISED = 2;
  localparam int ST_INPOS = 3;
  localparam int ST_HOMED = 4;
  localparam int ST_HOMING = 5;
  localparam int ST_POLE = 6;
  localparam int ST_CLAMP = 7;
  localparam int ST_FWD_INH = 8;
  localparam int ST_REV_INH = 9;
  // ----------------------------------------
  // timing
  // ----------------------------------------
  localparam int FILT_CYCLES = 4;
  localparam int NUM_CONTACTS = 12;
  localparam int POLE_CYCLES = 16;
  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [1:0] {FMT_PULSE_DIR, FMT_FWD_REV, FMT_QUAD} sdio_fmt_e;
  typedef enum logic [1:0] {HOME_IDLE, HOME_SEEK, HOME_DONE} sdio_home_e;
endpackage

// ===== test/sdio_chk.sv
// concurrent checks on the contact i/o block ports
`timescale 1ns/1ps
module sdio_chk (
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire logic servo_enable_in,
  input wire logic torque_clamp_in,
  input wire logic fwd_limit_in,
  input wire logic rev_limit_in,
  input wire logic psel,
  input wire logic penable,
  input wire logic [7:0] paddr,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic servo_ready_out,
  input wire logic fault_ok_out,
  input wire logic motor_power_out,
  input wire logic torque_limit_out,
  input wire logic fwd_inhibit_out,
  input wire logic rev_inhibit_out,
  input wire logic pole_est_out,
  input wire logic homing_done_out,
  input wire logic brake_release_out
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (rst_in);
  // ----------------------------------------
  // contact outputs
  // ----------------------------------------
  a_brake_follows: assert property (brake_release_out == motor_power_out)
    else $error("brake release differs from motor power");
  a_power_removed: assert property (!servo_enable_in [*8] |-> ##2 !motor_power_out)
    else $error("motor still powered with enable off");
  a_clamp_applies: assert property (torque_clamp_in [*4] |=> torque_limit_out)
    else $error("torque limit not applied");
  a_fwd_inhibit: assert property (!fwd_limit_in [*8] |-> ##2 fwd_inhibit_out)
    else $error("forward motion not inhibited");
  a_rev_inhibit: assert property (!rev_limit_in [*8] |-> ##2 rev_inhibit_out)
    else $error("reverse motion not inhibited");
  // estimation window is a fixed length while energise_w holds, so both ends are pinned
  a_pole_width: assert property ($rose(pole_est_out) |-> ##15 pole_est_out ##1 !pole_est_out)
    else $error("pole estimation pulse length wrong");
  a_trip_cuts: assert property ($fell(fault_ok_out) |-> !motor_power_out && !servo_ready_out)
    else $error("trip left power or ready on");
  a_ready_no_alarm: assert property (servo_ready_out |-> fault_ok_out)
    else $error("ready while alarm latched");
  // ----------------------------------------
  // register bus
  // ----------------------------------------
  a_apb_one_wait: assert property (psel && $rose(penable) |-> !pready ##1 pready)
    else $error("bus answer not after one wait state");
  a_apb_bad_addr: assert property (pready && paddr > 8'h18 |-> pslverr)
    else $error("unmapped address not refused");
  c_pole: cover property ($rose(pole_est_out));
  c_homed: cover property ($rose(homing_done_out));
  c_trip: cover property ($fell(fault_ok_out));
endmodule

bind sdio_core sdio_chk u_chk (.*);

// ===== test/sdio_host_model.sv
// host contact model driving the block's contact inputs
`timescale 1ns/1ps
module sdio_host_model (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic rude_in,
  input wire logic [10:0] req_in,
  output logic [10:0] pins_out
);
  // ----------------------------------------
  // contact drive
  // ----------------------------------------
  // a polite host never clears with enable on; rude_in lets a test misbehave
  wire logic clr_ok = !req_in[10] || rude_in;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      pins_out <= 11'h0C0;
    end else begin
      pins_out <= {req_in[10], req_in[9] & clr_ok, req_in[8:0]};
    end
  end
endmodule

// ===== test/sdio_core_test.sv
// self-checking bench for the contact i/o block
`timescale 1ns/1ps
module sdio_core_test;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic rude = 1'b0;
  logic trip = 1'b0;
  logic enc = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [10:0] req = 11'h0C0;
  logic [10:0] pins;
  logic [31:0] prdata, rd, base, d, m;
  logic pready, pslverr, err, ready, fok, pwr, tlim, finh, rinh, pole, inpos, hdone, hact, brake;
  // en clamp fwd rev | power limit fwd_inh rev_inh
  logic [7:0] rows [6] = '{8'h30, 8'hB8, 8'hFC, 8'hDE, 8'hA9, 8'h03};
  logic [1:0] qseq [4] = '{2'b10, 2'b11, 2'b01, 2'b00};
  int n_fail = 0;
  int cmp_count = 0;
  int f, k;
  always #4 clk = ~clk;
  sdio_host_model host (.clk_in(clk), .rst_in(rst), .rude_in(rude), .req_in(req), .pins_out(pins));
  sdio_core dut (.mclk_in(clk), .rst_in(rst), .servo_enable_in(pins[10]), .alarm_clear_in(pins[9]),
    .torque_clamp_in(pins[8]), .fwd_limit_in(pins[7]), .rev_limit_in(pins[6]), .home_switch_in(pins[5]),
    .homing_start_in(pins[4]), .pulse_input_gate(pins[3]), .deviation_clear_in(pins[2]),
    .cmd_pulse_pos(pins[1]), .cmd_dir_pos(pins[0]), .fault_trip_in(trip), .enc_step_in(enc),
    .enc_dir_in(1'b0), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .servo_ready_out(ready), .fault_ok_out(fok),
    .motor_power_out(pwr), .torque_limit_out(tlim), .fwd_inhibit_out(finh), .rev_inhibit_out(rinh),
    .pole_est_out(pole), .in_position_out(inpos), .homing_done_out(hdone), .homing_active_out(hact),
    .brake_release_out(brake));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic end_sim;
    if (n_fail == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    int i;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= dat;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (i == 20) begin
      n_fail++;
      end_sim();
    end
  endtask
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    tick(16);
    chk({pwr, ready, fok, finh, rinh}, 5'b00011, "reset outputs");
    rst <= 1'b0;
    apb(1'b0, sdio_pkg::ADDR_CTRL, 32'h0);
    chk(rd, sdio_pkg::CTRL_RESET, "ctrl reset");
    apb(1'b0, sdio_pkg::ADDR_INPOS, 32'h0);
    chk(rd, sdio_pkg::INPOS_RESET, "inpos reset");
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0, "unmapped read");
    chk(err, 1'b1, "unmapped error");
    for (k = 0; k < 6; k++) begin
      req[10] <= rows[k][7];
      req[8] <= rows[k][6];
      req[7:6] <= rows[k][5:4];
      tick(12);
      chk({pwr, tlim, finh, rinh}, rows[k][3:0], "row outputs");
      chk(brake, rows[k][3], "brake");
    end
    chk({fok, ready}, 2'b11, "idle ready");
    apb(1'b1, sdio_pkg::ADDR_CTRL, 32'h0);
    tick(2);
    chk(ready, 1'b0, "ready no mains");
    // pole window only for the two special settings
    req[7:6] <= 2'b11;
    for (f = 3; f < 6; f++) begin
      apb(1'b1, sdio_pkg::ADDR_CTRL, sdio_pkg::CTRL_RESET | (f << 4));
      req[10] <= 1'b1;
      tick(12);
      chk(pole, f != 3, "pole window");
      tick(20);
      req[10] <= 1'b0;
      tick(12);
    end
    apb(1'b1, sdio_pkg::ADDR_CTRL, sdio_pkg::CTRL_RESET);
    req[10] <= 1'b1;
    tick(12);
    trip <= 1'b1;
    tick(12);
    chk({fok, ready, pwr, brake}, 4'h0, "trip");
    trip <= 1'b0;
    tick(12);
    rude <= 1'b1;
    req[9] <= 1'b1;
    tick(12);
    req[9] <= 1'b0;
    tick(12);
    chk(fok, 1'b0, "clear with enable");
    rude <= 1'b0;
    req[10] <= 1'b0;
    tick(12);
    req[9] <= 1'b1;
    tick(12);
    req[9] <= 1'b0;
    chk({fok, ready}, 2'b11, "alarm cleared");
    req[10] <= 1'b1;
    tick(12);
    req[4] <= 1'b1;
    tick(12);
    chk(hact, 1'b1, "homing active");
    req[5] <= 1'b1;
    tick(12);
    chk({hdone, hact}, 2'b10, "homing done");
    req[5:4] <= 2'b00;
    // formats 0..2 with the gate open, then format 0 with it shut
    for (f = 0; f < 4; f++) begin
      apb(1'b1, sdio_pkg::ADDR_CTRL, sdio_pkg::CTRL_RESET | (f % 3));
      req[3] <= (f != 3);
      tick(10);
      apb(1'b0, sdio_pkg::ADDR_CMDPOS, 32'h0);
      base = rd;
      for (k = 0; k < 4; k++) begin
        req[1:0] <= (f == 2) ? qseq[k] : {~k[0], 1'b0};
        tick(6);
      end
      tick(6);
      apb(1'b0, sdio_pkg::ADDR_CMDPOS, 32'h0);
      d = rd - base;
      if (f == 2 && d[31]) d = -d;
      chk(d, f == 3 ? 0 : (f == 2 ? 4 : 2), "pulse count");
    end
    // a two-cycle dip on a limit must not reach the outputs
    req[7] <= 1'b0;
    tick(2);
    req[7] <= 1'b1;
    tick(3);
    chk(finh, 1'b0, "limit glitch");
    for (k = 0; k < 12; k++) begin
      enc <= 1'b1;
      tick(6);
      enc <= 1'b0;
      tick(6);
    end
    chk(inpos, 1'b0, "out of position");
    req[2] <= 1'b1;
    tick(12);
    req[2] <= 1'b0;
    tick(12);
    apb(1'b0, sdio_pkg::ADDR_ERR, 32'h0);
    chk(rd, 32'h0, "error count");
    apb(1'b0, sdio_pkg::ADDR_MEASPOS, 32'h0);
    m = rd;
    apb(1'b0, sdio_pkg::ADDR_CMDPOS, 32'h0);
    chk(rd, m, "cmd equals meas");
    chk(inpos, 1'b1, "in position");
    end_sim();
  end
endmodule
